// >>> acs_pkg.sv
// Overview of operation
// - Each channel map bit reads one when its channel is enabled, zero otherwise.
// - Writing one to an enable strobe bit sets that map bit; zeros change nothing.
// - Writing one to a disable strobe bit clears that map bit; zeros change nothing.
// - The channel map resets to all zeros, every channel disabled.
// - Channel count is a parameter; unimplemented map bits ignore enable writes.
// - Plain 8-bit and 10-bit conversion taken straight from the 10-bit core.
// - 11-bit mode combines 4 consecutive samples into one result.
// - 12-bit mode combines 16 consecutive samples into one result.
// - Every channel's result goes through one shared result register.
// - A trigger converts all enabled channels, or channels 0 and 1 in touch mode; sources software, pin and timer.
// - The trigger pin fires on rising, falling or either edge, as selected.
// - A 16-bit timer issues periodic conversion triggers.
// - Touch mode sequencer drives pad controls and runs touch conversions unaided.
// - Exactly one peripheral DMA channel moves results without the processor.
package acs_pkg;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PERIOD = 8'h0C;
   localparam logic [7:0] OFS_RESULT = 8'h10;
   localparam logic [7:0] OFS_ENABLE = 8'h40;
   localparam logic [7:0] OFS_DISABLE = 8'h44;
   localparam logic [7:0] OFS_MAP = 8'h48;
   localparam logic [31:0] MAP_RESET = 32'h0000_0000;
   localparam logic [15:0] PERIOD_RESET = 16'h00FF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CMD_START_BIT = 0;
   localparam int RES_VALID_BIT = 31;
   localparam int RES_CHAN_LSB = 16;
   localparam int RAW_W = 10;
   localparam int VAL_W = 12;
   localparam int ACC_W = 14;
   localparam int CHAN_W = 5;
   localparam int TIMER_W = 16;
   // Pad drive patterns: {x_plus, x_minus, y_plus, y_minus}
   localparam logic [3:0] PAD_IDLE = 4'h0;
   localparam logic [3:0] PAD_X_MEAS = 4'hC;
   localparam logic [3:0] PAD_Y_MEAS = 4'h3;
   localparam logic [4:0] TOUCH_X_CH = 5'h00;
   localparam logic [4:0] TOUCH_Y_CH = 5'h01;

   typedef enum logic [1:0] {
      RES_8 = 2'h0,
      RES_10 = 2'h1,
      RES_11 = 2'h2,
      RES_12 = 2'h3
   } acs_res_t;

   typedef enum logic [1:0] {
      TRG_SOFT = 2'h0,
      TRG_PIN = 2'h1,
      TRG_TIMER = 2'h2,
      TRG_NONE = 2'h3
   } acs_trig_t;

   typedef enum logic [1:0] {
      EDGE_RISE = 2'h0,
      EDGE_FALL = 2'h1,
      EDGE_ANY = 2'h2,
      EDGE_OFF = 2'h3
   } acs_edge_t;

   // Control register layout, bit 31 downward
   typedef struct packed {
      logic [22:0] unused;
      logic dma_en;
      logic touch_mode;
      acs_edge_t edge_sel;
      acs_trig_t trig_src;
      acs_res_t res;
      logic enable;
   } acs_ctrl_t;

   typedef struct packed {
      logic [CHAN_W-1:0] chan;
      logic [VAL_W-1:0] value;
   } acs_result_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARM = 2'b01,
      ST_WAIT = 2'b11,
      ST_STORE = 2'b10
   } acs_state_t;
endpackage

// >>> acs_sequencer.sv
`timescale 1ns/1ps
module acs_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("acs_fifo depth must be a power of two, at least 2");
   end

   assign in_ready = count_reg != (AW+1)'(DEPTH);
   assign out_valid = count_reg != '0;
   assign out_data = mem[rd_ptr_reg];
   assign level = count_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         if (push && !pop) begin
            count_reg <= count_reg + (AW+1)'(1);
         end else if (pop && !push) begin
            count_reg <= count_reg - (AW+1)'(1);
         end
      end
   end
endmodule

module acs_sequencer #(
   parameter int NUM_CH = 8,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trigger_pin,
   output logic conv_start,
   output logic [4:0] conv_chan,
   input wire logic conv_done,
   input wire logic [9:0] conv_data,
   output logic [3:0] pad_ctrl,
   output logic dma_req,
   output logic [31:0] dma_data,
   input wire logic dma_ack
);
   localparam int RW = acs_pkg::CHAN_W + acs_pkg::VAL_W;

   if (NUM_CH < 2 || NUM_CH > 32) begin : g_bad_ch
      $error("acs_sequencer supports 2 to 32 channels");
   end

   acs_pkg::acs_ctrl_t ctrl_reg;
   acs_pkg::acs_state_t state_reg;
   logic [31:0] ch_map_reg;
   logic [31:0] scan_reg;
   logic [15:0] period_reg;
   logic [15:0] timer_reg;
   logic pin_prev_reg;
   logic [3:0] sample_reg;
   logic [acs_pkg::ACC_W-1:0] acc_reg;
   logic aw_got_reg;
   logic w_got_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic s_axi_awready_reg;
   logic s_axi_wready_reg;
   logic s_axi_bvalid_reg;
   logic [1:0] s_axi_bresp_reg;
   logic s_axi_arready_reg;
   logic s_axi_rvalid_reg;
   logic [31:0] s_axi_rdata_reg;
   logic [1:0] s_axi_rresp_reg;
   logic conv_start_reg;
   logic [4:0] conv_chan_reg;
   logic [3:0] pad_ctrl_reg;
   logic dma_req_reg;
   logic [31:0] dma_data_reg;

   logic [31:0] impl_mask;
   logic [31:0] wmask;
   logic do_write;
   logic rd_take;
   logic soft_trig;
   logic pin_rise;
   logic pin_fall;
   logic pin_trig;
   logic timer_trig;
   logic trig_fire;
   logic [3:0] need_last;
   logic [4:0] next_chan;
   logic [acs_pkg::VAL_W-1:0] scaled;
   acs_pkg::acs_result_t push_word;
   logic push_ready;
   logic [RW-1:0] head_word;
   acs_pkg::acs_result_t head;
   logic head_valid;
   logic pop;
   logic bus_pop;
   logic [$clog2(FIFO_DEPTH):0] fifo_level;
   logic [31:0] head_reg_view;

   assign impl_mask = 32'hFFFF_FFFF >> (32 - NUM_CH);
   assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid_reg;
   assign rd_take = s_axi_arvalid && s_axi_arready_reg;

   // AXI write path: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_axi_awready_reg <= 1'b0;
         s_axi_wready_reg <= 1'b0;
         s_axi_bvalid_reg <= 1'b0;
         s_axi_bresp_reg <= acs_pkg::RESP_OKAY;
      end else begin
         s_axi_awready_reg <= !aw_got_reg && !(s_axi_awvalid && s_axi_awready_reg);
         s_axi_wready_reg <= !w_got_reg && !(s_axi_wvalid && s_axi_wready_reg);
         if (s_axi_awvalid && s_axi_awready_reg) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready_reg) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid_reg <= 1'b1;
            case (awaddr_reg)
               acs_pkg::OFS_CTRL, acs_pkg::OFS_CMD, acs_pkg::OFS_PERIOD,
               acs_pkg::OFS_ENABLE, acs_pkg::OFS_DISABLE:
                  s_axi_bresp_reg <= acs_pkg::RESP_OKAY;
               default: s_axi_bresp_reg <= acs_pkg::RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid_reg && s_axi_bready) begin
            s_axi_bvalid_reg <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            s_axi_awready_reg <= 1'b1;
            s_axi_wready_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= '0;
         period_reg <= acs_pkg::PERIOD_RESET;
      end else if (do_write) begin
         if (awaddr_reg == acs_pkg::OFS_CTRL) begin
            ctrl_reg <= (ctrl_reg & ~wmask) | (wdata_reg & wmask);
         end
         if (awaddr_reg == acs_pkg::OFS_PERIOD) begin
            period_reg <= (period_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
         end
      end
   end

   // Channel map: only software touches it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ch_map_reg <= acs_pkg::MAP_RESET;
      end else if (do_write && awaddr_reg == acs_pkg::OFS_ENABLE) begin
         ch_map_reg <= ch_map_reg | (wdata_reg & wmask & impl_mask);
      end else if (do_write && awaddr_reg == acs_pkg::OFS_DISABLE) begin
         ch_map_reg <= ch_map_reg & ~(wdata_reg & wmask);
      end
   end

   assign head = acs_pkg::acs_result_t'(head_word);
   // Empty FIFO reads as zero so stale slots never leak out
   assign head_reg_view = head_valid ? {1'b1, 10'h000, head.chan, 4'h0, head.value}
      : 32'h0000_0000;
   assign bus_pop = rd_take && s_axi_araddr == acs_pkg::OFS_RESULT;

   // AXI read path: one beat, answer one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready_reg <= 1'b0;
         s_axi_rvalid_reg <= 1'b0;
         s_axi_rdata_reg <= 32'h0000_0000;
         s_axi_rresp_reg <= acs_pkg::RESP_OKAY;
      end else if (rd_take) begin
         s_axi_arready_reg <= 1'b0;
         s_axi_rvalid_reg <= 1'b1;
         s_axi_rresp_reg <= acs_pkg::RESP_OKAY;
         case (s_axi_araddr)
            acs_pkg::OFS_CTRL: s_axi_rdata_reg <= ctrl_reg;
            acs_pkg::OFS_CMD: s_axi_rdata_reg <= 32'h0000_0000;
            acs_pkg::OFS_STATUS: s_axi_rdata_reg <= {16'h0000, 8'(fifo_level),
               4'h0, head_valid, dma_req_reg, state_reg};
            acs_pkg::OFS_PERIOD: s_axi_rdata_reg <= {16'h0000, period_reg};
            acs_pkg::OFS_RESULT: s_axi_rdata_reg <= head_reg_view;
            acs_pkg::OFS_ENABLE, acs_pkg::OFS_DISABLE: s_axi_rdata_reg <= 32'h0000_0000;
            acs_pkg::OFS_MAP: s_axi_rdata_reg <= ch_map_reg;
            default: begin
               s_axi_rdata_reg <= 32'h0000_0000;
               s_axi_rresp_reg <= acs_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid_reg && s_axi_rready) begin
         s_axi_rvalid_reg <= 1'b0;
         s_axi_arready_reg <= 1'b1;
      end else begin
         s_axi_arready_reg <= !s_axi_rvalid_reg;
      end
   end

   // Trigger sources
   assign soft_trig = do_write && awaddr_reg == acs_pkg::OFS_CMD
      && wdata_reg[acs_pkg::CMD_START_BIT] && wstrb_reg[0];
   assign pin_rise = trigger_pin && !pin_prev_reg;
   assign pin_fall = !trigger_pin && pin_prev_reg;
   always_comb begin
      case (ctrl_reg.edge_sel)
         acs_pkg::EDGE_RISE: pin_trig = pin_rise;
         acs_pkg::EDGE_FALL: pin_trig = pin_fall;
         acs_pkg::EDGE_ANY: pin_trig = pin_rise || pin_fall;
         default: pin_trig = 1'b0;
      endcase
   end
   assign timer_trig = ctrl_reg.trig_src == acs_pkg::TRG_TIMER && timer_reg >= period_reg;
   always_comb begin
      case (ctrl_reg.trig_src)
         acs_pkg::TRG_SOFT: trig_fire = soft_trig;
         acs_pkg::TRG_PIN: trig_fire = pin_trig;
         acs_pkg::TRG_TIMER: trig_fire = timer_trig || soft_trig;
         default: trig_fire = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev_reg <= 1'b0;
      end else begin
         pin_prev_reg <= trigger_pin;
      end
   end

   // Free-running period timer, restarts on each trigger it issues
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_reg <= 16'h0000;
      end else if (!ctrl_reg.enable || ctrl_reg.trig_src != acs_pkg::TRG_TIMER) begin
         timer_reg <= 16'h0000;
      end else if (timer_trig) begin
         timer_reg <= 16'h0000;
      end else begin
         timer_reg <= timer_reg + 16'h0001;
      end
   end

   always_comb begin
      case (ctrl_reg.res)
         acs_pkg::RES_11: need_last = 4'h3;
         acs_pkg::RES_12: need_last = 4'hF;
         default: need_last = 4'h0;
      endcase
   end

   always_comb begin
      case (ctrl_reg.res)
         acs_pkg::RES_8: scaled = {4'h0, acc_reg[9:2]};
         acs_pkg::RES_10: scaled = {2'h0, acc_reg[9:0]};
         acs_pkg::RES_11: scaled = {1'b0, acc_reg[11:1]};
         default: scaled = acc_reg[13:2];
      endcase
   end

   always_comb begin
      next_chan = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (scan_reg[i]) begin
            next_chan = 5'(i);
         end
      end
   end

   assign push_word.chan = conv_chan_reg;
   assign push_word.value = scaled;

   // Sequencer: one channel at a time, stalls while the FIFO is full
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= acs_pkg::ST_IDLE;
         scan_reg <= 32'h0000_0000;
         sample_reg <= 4'h0;
         acc_reg <= '0;
         conv_start_reg <= 1'b0;
         conv_chan_reg <= 5'h00;
         pad_ctrl_reg <= acs_pkg::PAD_IDLE;
      end else begin
         conv_start_reg <= 1'b0;
         case (state_reg)
            acs_pkg::ST_IDLE: begin
               pad_ctrl_reg <= acs_pkg::PAD_IDLE;
               if (ctrl_reg.enable && trig_fire) begin
                  state_reg <= acs_pkg::ST_ARM;
                  scan_reg <= ctrl_reg.touch_mode ? 32'h0000_0003 : ch_map_reg & impl_mask;
               end
            end
            acs_pkg::ST_ARM: begin
               sample_reg <= 4'h0;
               acc_reg <= '0;
               if (scan_reg == 32'h0000_0000) begin
                  state_reg <= acs_pkg::ST_IDLE;
               end else begin
                  state_reg <= acs_pkg::ST_WAIT;
                  conv_start_reg <= 1'b1;
                  if (ctrl_reg.touch_mode) begin
                     conv_chan_reg <= scan_reg[0] ? acs_pkg::TOUCH_X_CH : acs_pkg::TOUCH_Y_CH;
                     pad_ctrl_reg <= scan_reg[0] ? acs_pkg::PAD_X_MEAS : acs_pkg::PAD_Y_MEAS;
                  end else begin
                     conv_chan_reg <= next_chan;
                  end
               end
            end
            acs_pkg::ST_WAIT: begin
               if (conv_done) begin
                  acc_reg <= acc_reg + acs_pkg::ACC_W'(conv_data);
                  sample_reg <= sample_reg + 4'h1;
                  if (sample_reg == need_last) begin
                     state_reg <= acs_pkg::ST_STORE;
                  end else begin
                     conv_start_reg <= 1'b1;
                  end
               end
            end
            acs_pkg::ST_STORE: begin
               if (push_ready) begin
                  state_reg <= acs_pkg::ST_ARM;
                  scan_reg <= scan_reg & (scan_reg - 32'h0000_0001);
               end
            end
            default: state_reg <= acs_pkg::ST_IDLE;
         endcase
      end
   end

   acs_fifo #(
      .WIDTH(RW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_data(push_word),
      .in_valid(state_reg == acs_pkg::ST_STORE),
      .in_ready(push_ready),
      .out_data(head_word),
      .out_valid(head_valid),
      .out_ready(pop),
      .level(fifo_level)
   );

   // Single DMA channel drains the shared result
   assign pop = (dma_ack && dma_req_reg) || bus_pop;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_req_reg <= 1'b0;
         dma_data_reg <= 32'h0000_0000;
      end else begin
         dma_req_reg <= head_valid && ctrl_reg.dma_en && !pop;
         dma_data_reg <= head_reg_view;
      end
   end

   assign s_axi_awready = s_axi_awready_reg;
   assign s_axi_wready = s_axi_wready_reg;
   assign s_axi_bvalid = s_axi_bvalid_reg;
   assign s_axi_bresp = s_axi_bresp_reg;
   assign s_axi_arready = s_axi_arready_reg;
   assign s_axi_rvalid = s_axi_rvalid_reg;
   assign s_axi_rdata = s_axi_rdata_reg;
   assign s_axi_rresp = s_axi_rresp_reg;
   assign conv_start = conv_start_reg;
   assign conv_chan = conv_chan_reg;
   assign pad_ctrl = pad_ctrl_reg;
   assign dma_req = dma_req_reg;
   assign dma_data = dma_data_reg;

   map_reset_a: assert property (@(posedge aclk) !aresetn |=> ch_map_reg == 32'h0000_0000)
      else $error("channel map not cleared by reset");
   map_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && s_axi_araddr == acs_pkg::OFS_MAP |=> s_axi_rdata == $past(ch_map_reg))
      else $error("map read differs from channel map");
   enable_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && awaddr_reg == acs_pkg::OFS_ENABLE && wstrb_reg == 4'hF
      |=> (ch_map_reg & $past(wdata_reg & impl_mask)) == $past(wdata_reg & impl_mask)
         && (ch_map_reg & ~$past(wdata_reg)) == ($past(ch_map_reg) & ~$past(wdata_reg)))
      else $error("enable strobe did not set only its bits");
   disable_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && awaddr_reg == acs_pkg::OFS_DISABLE && wstrb_reg == 4'hF
      |=> ch_map_reg == ($past(ch_map_reg) & ~$past(wdata_reg)))
      else $error("disable strobe wrong");
   unimpl_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ch_map_reg & ~impl_mask) == 32'h0000_0000)
      else $error("unimplemented channel enabled");
   busy_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == acs_pkg::ST_WAIT && trig_fire && !conv_done
      |=> state_reg == acs_pkg::ST_WAIT && $stable(scan_reg))
      else $error("trigger disturbed a running sequence");
   avg_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == acs_pkg::ST_WAIT && $past(state_reg) == acs_pkg::ST_WAIT && $rose(conv_start)
      |-> sample_reg != 4'h0 && sample_reg <= need_last)
      else $error("extra sample in averaging");
   scale_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == acs_pkg::ST_STORE && ctrl_reg.res == acs_pkg::RES_11
      |-> scaled == {1'b0, acc_reg[11:1]} && sample_reg == 4'h4)
      else $error("11-bit result badly formed");
   pin_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == acs_pkg::ST_IDLE && ctrl_reg.enable && ctrl_reg.trig_src == acs_pkg::TRG_PIN
      && ctrl_reg.edge_sel == acs_pkg::EDGE_FALL && pin_fall |=> state_reg == acs_pkg::ST_ARM)
      else $error("falling pin edge missed");
   touch_pads_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_reg.touch_mode && state_reg == acs_pkg::ST_WAIT |-> pad_ctrl != acs_pkg::PAD_IDLE)
      else $error("touch conversion with pads idle");
   dma_valid_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dma_req |-> head_valid && dma_data == head_reg_view)
      else $error("dma request without result");
endmodule

// >>> acs_core_model.sv
`timescale 1ns/1ps
module acs_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic conv_start,
   input wire logic [4:0] conv_chan,
   input wire logic [3:0] delay,
   output logic conv_done,
   output logic [9:0] conv_data
);
   logic busy_reg;
   logic [3:0] cnt_reg;
   // Data toggles outside done so a stale sample never looks valid
   always_ff @(posedge aclk) begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (!aresetn) begin
         busy_reg <= 1'b0;
         conv_data <= 10'h2aa;
      end else if (conv_start) begin
         busy_reg <= 1'b1;
         cnt_reg <= delay;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 4'h1;
         if (cnt_reg == 4'h0) begin
            busy_reg <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= 10'h100 + {2'h0, conv_chan, 3'h0};
         end
      end
   end
endmodule

// >>> acs_sequencer_tb.sv
`timescale 1ns/1ps
module acs_sequencer_tb;
   logic aclk = 1'b0, aresetn = 1'b0, pin = 1'b0, dma_ack = 1'b0, dma_on = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rd, rdata, dma_data;
   logic [3:0] dly = 4'h3, pad_ctrl;
   logic awready, wready, bvalid, arready, rvalid, conv_start, conv_done, dma_req;
   logic [1:0] bresp, rresp, rr;
   logic [4:0] conv_chan;
   logic [9:0] conv_data;
   logic [8:0] touch_q[$];
   int fail_count = 0, samples_checked = 0, starts = 0, pops = 0, cyc = 0;

   acs_sequencer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .trigger_pin(pin), .conv_start(conv_start),
      .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data),
      .pad_ctrl(pad_ctrl), .dma_req(dma_req), .dma_data(dma_data), .dma_ack(dma_ack));
   acs_core_model core (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
      .conv_chan(conv_chan), .delay(dly), .conv_done(conv_done), .conv_data(conv_data));

   initial begin
      forever #2 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cyc++;
      if (conv_start === 1'b1) begin
         starts++;
         touch_q.push_back({pad_ctrl, conv_chan});
      end
      if (dma_req === 1'b1 && dma_ack === 1'b1) begin
         if (pops < 40) chk(dma_data, res_word({2'h0, pops[2:0]}, 2'h1));
         pops++;
      end
      dma_ack <= dma_on && dma_req === 1'b1 && !dma_ack;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (awready === 1'b1) aw = 1'b0;
         if (wready === 1'b1) w = 1'b0;
         awvalid <= aw;
         wvalid <= w;
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
   endtask

   task automatic rdr(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd = rdata;
      rr = rresp;
      @(posedge aclk);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      rdr(a);
      chk(rd, exp);
      chk({30'h0, rr}, {30'h0, er});
   endtask

   // Polls the state field; a short lead-in lets a trigger get through
   task automatic idle();
      repeat (8) @(posedge aclk);
      do rdr(acs_pkg::OFS_STATUS); while (rd[1:0] !== 2'b00);
   endtask

   function automatic logic [31:0] res_word(input logic [4:0] ch, input logic [1:0] r);
      logic [9:0] raw;
      logic [11:0] v;
      raw = 10'h100 + {2'h0, ch, 3'h0};
      v = (r == 2'h0) ? {4'h0, raw[9:2]} : (r == 2'h1) ? {2'h0, raw} :
         (r == 2'h2) ? {1'h0, raw, 1'h0} : {raw, 2'h0};
      return {1'b1, 10'h000, ch, 4'h0, v};
   endfunction

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rc(acs_pkg::OFS_MAP, acs_pkg::MAP_RESET, acs_pkg::RESP_OKAY);
      rc(acs_pkg::OFS_PERIOD, {16'h0000, acs_pkg::PERIOD_RESET}, acs_pkg::RESP_OKAY);
      wr(acs_pkg::OFS_ENABLE, 32'h0000_000D, acs_pkg::RESP_OKAY);
      wr(acs_pkg::OFS_DISABLE, 32'h0000_0004, acs_pkg::RESP_OKAY);
      rc(acs_pkg::OFS_MAP, 32'h0000_0009, acs_pkg::RESP_OKAY);
      wr(acs_pkg::OFS_MAP, 32'h0000_0000, acs_pkg::RESP_SLVERR);
      rc(8'h80, 32'h0000_0000, acs_pkg::RESP_SLVERR);
      $display("registers test done");
      for (int r = 0; r < 4; r++) begin
         starts = 0;
         wr(acs_pkg::OFS_CTRL, {25'h0, 4'hC, r[1:0], 1'b1}, acs_pkg::RESP_OKAY);
         wr(acs_pkg::OFS_CMD, 32'h0000_0001, acs_pkg::RESP_OKAY);
         wr(acs_pkg::OFS_CMD, 32'h0000_0001, acs_pkg::RESP_OKAY);
         idle();
         chk(starts, (r < 2) ? 2 : (r == 2) ? 8 : 32);
         rc(acs_pkg::OFS_RESULT, res_word(5'h00, r[1:0]), acs_pkg::RESP_OKAY);
         rc(acs_pkg::OFS_RESULT, res_word(5'h03, r[1:0]), acs_pkg::RESP_OKAY);
         rc(acs_pkg::OFS_RESULT, 32'h0000_0000, acs_pkg::RESP_OKAY);
      end
      $display("resolution test done");
      dly <= 4'h0;
      wr(acs_pkg::OFS_ENABLE, 32'hFFFF_FFFF, acs_pkg::RESP_OKAY);
      rc(acs_pkg::OFS_MAP, 32'h0000_00FF, acs_pkg::RESP_OKAY);
      for (int e = 0; e < 3; e++) begin
         starts = 0;
         wr(acs_pkg::OFS_CTRL, {25'h0, e[1:0], 4'h5, 1'b1}, acs_pkg::RESP_OKAY);
         pin <= 1'b1;
         idle();
         pin <= 1'b0;
         idle();
         chk(starts, (e == 2) ? 16 : 8);
      end
      $display("trigger pin test done");
      starts = 0;
      wr(acs_pkg::OFS_CTRL, 32'h0000_0063, acs_pkg::RESP_OKAY);
      wr(acs_pkg::OFS_CMD, 32'h0000_0001, acs_pkg::RESP_OKAY);
      repeat (40) @(posedge aclk);
      rdr(acs_pkg::OFS_STATUS);
      chk({24'h0, rd[15:8]}, 32'h0000_0020);
      chk(starts, 1);
      dma_on <= 1'b1;
      wr(acs_pkg::OFS_CTRL, 32'h0000_0163, acs_pkg::RESP_OKAY);
      idle();
      do rdr(acs_pkg::OFS_STATUS); while (rd[15:8] !== 8'h00);
      chk(pops, 40);
      $display("buffer and dma test done");
      touch_q.delete();
      wr(acs_pkg::OFS_CTRL, 32'h0000_01E3, acs_pkg::RESP_OKAY);
      wr(acs_pkg::OFS_CMD, 32'h0000_0001, acs_pkg::RESP_OKAY);
      idle();
      chk(touch_q.size(), 2);
      chk({14'h0, touch_q[0], touch_q[1]}, {14'h0, 4'hC, 5'h00, 4'h3, 5'h01});
      chk({28'h0, pad_ctrl}, {28'h0, acs_pkg::PAD_IDLE});
      $display("touch test done");
      wr(acs_pkg::OFS_DISABLE, 32'h0000_00FC, acs_pkg::RESP_OKAY);
      wr(acs_pkg::OFS_PERIOD, 32'h0000_0028, acs_pkg::RESP_OKAY);
      starts = 0;
      wr(acs_pkg::OFS_CTRL, 32'h0000_0173, acs_pkg::RESP_OKAY);
      repeat (410) @(posedge aclk);
      chk({31'h0, starts >= 16 && starts <= 22}, 32'h0000_0001);
      $display("timer test done");
      finish_test();
   end
endmodule
